//--- inc/cfg_pkg.sv
// Constants, register map and types of the serial configuration port
package cfg_pkg;
  // Word layout
  localparam int NREG = 13;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int WORD_BITS = 24;
  localparam logic [4:0] CNT_LAST = 5'h17;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] RB_BITS_AFTER_FIRST = 5'h0F;
  localparam logic [4:0] RB_CNT_END = 5'h01;
  // Register map: address and writable bits of each stored register
  localparam logic [7:0] REG_ADDR [NREG] = '{
    8'h01, 8'h02, 8'h0A, 8'h0F, 8'h14, 8'h1C, 8'h23,
    8'h24, 8'h2A, 8'h2B, 8'h42, 8'h46, 8'hF0};
  localparam logic [15:0] REG_MASK [NREG] = '{
    16'h0011, 16'h2000, 16'hFFFF, 16'h07AA, 16'h00A5, 16'h7FFC, 16'hFFFF,
    16'hFEA5, 16'h0F0F, 16'h0F0F, 16'h8008, 16'hAE1D, 16'h8000};
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_READBACK_CTRL = 8'h01;
  // Array index of registers whose bits steer logic
  localparam int IDX_READBACK = 0;
  localparam int IDX_SYNC = 1;
  localparam int IDX_POWER_DOWN = 3;
  localparam int IDX_REF_SOURCE = 10;
  localparam int IDX_OUT_FORMAT = 11;
  localparam int IDX_EXT_REF = 12;
  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int READBACK_EN_BIT = 0;
  localparam int HIGH_ADDR_EN_BIT = 4;
  localparam int SYNC_EN_BIT = 13;
  localparam int PD_PIN_CFG_BIT = 10;
  localparam int REF_SRC_HI_BIT = 15;
  localparam int REF_SRC_LO_BIT = 3;
  localparam int TWO_LANE_BIT = 0;
  localparam int TWOS_COMP_BIT = 2;
  localparam int MSB_FIRST_BIT = 3;
  localparam int EXT_REF_EN_BIT = 15;
  localparam logic [1:0] REF_SRC_PINS = 2'h0;
  localparam logic [1:0] REF_SRC_VCM = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_PULSE_NS = 10;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_KHZ = 50000;
  localparam int SCLK_MAX_KHZ = 15000;
  localparam int SCLK_MIN_PERIOD_CYC = CLK_KHZ / SCLK_MAX_KHZ;
  // Readback sequencer states
  typedef enum logic {RB_IDLE, RB_SHIFT} rb_state_e;
endpackage

//--- inc/frame_if.sv
// Decoded serial frame events passed from the front end to the register file
`timescale 1ns/1ps
interface frame_if;
  logic bit_edge;
  logic addr_valid;
  logic [7:0] addr;
  logic word_valid;
  logic [23:0] word;
  modport src (output bit_edge, output addr_valid, output addr, output word_valid, output word);
  modport dst (input bit_edge, input addr_valid, input addr, input word_valid, input word);
endinterface

//--- rtl/serial_frame.sv
// Serial front end: edge detect, 24-bit word framing and address capture
`timescale 1ns/1ps
module serial_frame (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Serial pins
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic serial_input,
  // Frame events
  frame_if.src fr
);
  logic sclk_q_reg, sclk_q_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] sh_reg, sh_next;
  logic edge_reg, edge_next;
  logic av_reg, av_next;
  logic wv_reg, wv_next;
  logic rise;

  // Rising serial clock seen while selected; no timeout so any slow rate works
  assign rise = serial_clock & ~sclk_q_reg & ~select_n;

  // Shift and count; deselect drops an incomplete word
  always_comb
  begin
    sclk_q_next = serial_clock;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    edge_next = rise;
    av_next = 1'b0;
    wv_next = 1'b0;
    if (select_n)
    begin
      cnt_next = 5'h00;
    end
    else if (rise)
    begin
      sh_next = {sh_reg[22:0], serial_input};
      av_next = (cnt_reg == cfg_pkg::CNT_ADDR_LAST);
      if (cnt_reg == cfg_pkg::CNT_LAST)
      begin
        cnt_next = 5'h00;
        wv_next = 1'b1;
      end
      else
      begin
        cnt_next = cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_q_reg <= 1'b0;
      cnt_reg <= 5'h00;
      sh_reg <= 24'h000000;
      edge_reg <= 1'b0;
      av_reg <= 1'b0;
      wv_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sclk_q_reg <= sclk_q_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      edge_reg <= edge_next;
      av_reg <= av_next;
      wv_reg <= wv_next;
    end
  end

  assign fr.bit_edge = edge_reg;
  assign fr.addr_valid = av_reg;
  assign fr.addr = sh_reg[7:0];
  assign fr.word_valid = wv_reg;
  assign fr.word = sh_reg;

  sequence last_bit_s;
    clk_en && rise && cnt_reg == cfg_pkg::CNT_LAST;
  endsequence

  word_commit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    last_bit_s |=> wv_reg && cnt_reg == 5'h00)
    else $error("word not committed on 24th edge");

  deselect_drop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && select_n |=> cnt_reg == 5'h00 && !wv_reg)
    else $error("partial word survived deselect");

  shift_in_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && rise |=> sh_reg[0] == $past(serial_input) && edge_reg)
    else $error("serial bit not shifted in");
endmodule

//--- rtl/adc_serial_config_port.sv
// Register file, soft reset, readback and reference control of the ADC serial port
`timescale 1ns/1ps
module adc_serial_config_port (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Serial configuration pins
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic serial_input,
  output logic readback_output,
  output logic readback_output_oe_n,
  // Register contents for the datapath
  output logic [cfg_pkg::NREG*16-1:0] reg_flat,
  // Decoded control
  output logic ref_amp_powerdown,
  output logic vcm_ref_input,
  output logic two_lane_en,
  output logic msb_first_en,
  output logic twos_comp_en,
  output logic pd_pin_partial,
  output logic sync_enable
);
  frame_if fr ();

  serial_frame u_frame (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .select_n(select_n),
    .serial_clock(serial_clock),
    .serial_input(serial_input),
    .fr(fr)
  );

  logic [15:0] reg_q [cfg_pkg::NREG];
  logic [15:0] reg_next [cfg_pkg::NREG];
  logic soft_rst_reg, soft_rst_next;
  logic readback_on;
  logic [7:0] word_addr;
  logic wr_ok;

  // Readback enable gates every write but its own register
  assign readback_on = reg_q[cfg_pkg::IDX_READBACK][cfg_pkg::READBACK_EN_BIT];
  assign word_addr = fr.word[23:16];
  assign wr_ok = fr.word_valid &
    (~readback_on | (word_addr == cfg_pkg::ADDR_READBACK_CTRL));

  // Soft reset is a one-cycle pulse, so the bit always reads back cleared
  always_comb
  begin
    soft_rst_next = wr_ok & (word_addr == cfg_pkg::ADDR_SOFT_RESET) &
      fr.word[cfg_pkg::SOFT_RESET_BIT];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      soft_rst_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      soft_rst_reg <= soft_rst_next;
    end
  end

  // Stored registers; unmapped or reserved bits stay zero through the mask
  for (genvar i = 0; i < cfg_pkg::NREG; i++)
  begin : g_reg
    always_comb
    begin
      reg_next[i] = reg_q[i];
      if (soft_rst_reg)
      begin
        reg_next[i] = cfg_pkg::REG_RESET;
      end
      else if (wr_ok && word_addr == cfg_pkg::REG_ADDR[i])
      begin
        reg_next[i] = fr.word[15:0] & cfg_pkg::REG_MASK[i];
      end
    end

    // Async reset pin; all-zero defaults give the documented start-up modes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        reg_q[i] <= cfg_pkg::REG_RESET;
      end
      else if (clk_en)
      begin
        reg_q[i] <= reg_next[i];
      end
    end

    assign reg_flat[i*16 +: 16] = reg_q[i];
  end

  // Register value chosen by the readback address
  logic [15:0] rd_val;
  always_comb
  begin
    rd_val = 16'h0000;
    for (int k = 0; k < cfg_pkg::NREG; k++)
    begin
      if (fr.addr == cfg_pkg::REG_ADDR[k] && fr.addr != cfg_pkg::ADDR_READBACK_CTRL)
      begin
        rd_val = reg_q[k];
      end
    end
  end

  // Readback sequencer
  cfg_pkg::rb_state_e rb_state_reg, rb_state_next;
  logic [15:0] rb_shift_reg, rb_shift_next;
  logic [4:0] rb_cnt_reg, rb_cnt_next;
  logic rb_out_reg, rb_out_next;
  logic rb_oe_n_reg, rb_oe_n_next;

  // Bits change just after a rising edge so the controller takes them on the next one
  always_comb
  begin
    rb_state_next = rb_state_reg;
    rb_shift_next = rb_shift_reg;
    rb_cnt_next = rb_cnt_reg;
    rb_out_next = rb_out_reg;
    rb_oe_n_next = 1'b0;
    if (soft_rst_reg || !readback_on)
    begin
      rb_state_next = cfg_pkg::RB_IDLE;
      rb_shift_next = 16'h0000;
      rb_cnt_next = 5'h00;
      rb_out_next = 1'b0;
      rb_oe_n_next = 1'b1;
    end
    else if (fr.addr_valid)
    begin
      rb_state_next = cfg_pkg::RB_SHIFT;
      rb_out_next = rd_val[15];
      rb_shift_next = {rd_val[14:0], 1'b0};
      rb_cnt_next = cfg_pkg::RB_BITS_AFTER_FIRST;
    end
    else
    begin
      unique case (rb_state_reg)
        cfg_pkg::RB_IDLE:
        begin
          rb_cnt_next = 5'h00;
        end
        cfg_pkg::RB_SHIFT:
        begin
          if (fr.bit_edge)
          begin
            rb_out_next = rb_shift_reg[15];
            rb_shift_next = {rb_shift_reg[14:0], 1'b0};
            rb_cnt_next = rb_cnt_reg - 5'h01;
            if (rb_cnt_reg == cfg_pkg::RB_CNT_END)
            begin
              rb_state_next = cfg_pkg::RB_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rb_state_reg <= cfg_pkg::RB_IDLE;
      rb_shift_reg <= 16'h0000;
      rb_cnt_reg <= 5'h00;
      rb_out_reg <= 1'b0;
      rb_oe_n_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      rb_state_reg <= rb_state_next;
      rb_shift_reg <= rb_shift_next;
      rb_cnt_reg <= rb_cnt_next;
      rb_out_reg <= rb_out_next;
      rb_oe_n_reg <= rb_oe_n_next;
    end
  end

  assign readback_output = rb_out_reg;
  assign readback_output_oe_n = rb_oe_n_reg;

  // Reference mode decode, registered so the analog controls never glitch
  logic ext_mode;
  logic [1:0] ref_src;
  logic ref_pd_reg, ref_pd_next;
  logic vcm_in_reg, vcm_in_next;

  assign ext_mode = reg_q[cfg_pkg::IDX_READBACK][cfg_pkg::HIGH_ADDR_EN_BIT] &
    reg_q[cfg_pkg::IDX_EXT_REF][cfg_pkg::EXT_REF_EN_BIT];
  assign ref_src = {reg_q[cfg_pkg::IDX_REF_SOURCE][cfg_pkg::REF_SRC_HI_BIT],
    reg_q[cfg_pkg::IDX_REF_SOURCE][cfg_pkg::REF_SRC_LO_BIT]};

  // Other source codes fall back to the internal references
  always_comb
  begin
    ref_pd_next = ext_mode & (ref_src == cfg_pkg::REF_SRC_PINS);
    vcm_in_next = ext_mode & (ref_src == cfg_pkg::REF_SRC_VCM);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_pd_reg <= 1'b0;
      vcm_in_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_pd_reg <= ref_pd_next;
      vcm_in_reg <= vcm_in_next;
    end
  end

  assign ref_amp_powerdown = ref_pd_reg;
  assign vcm_ref_input = vcm_in_reg;

  // Output format, power-down pin and sync enable controls straight from register bits
  assign two_lane_en = reg_q[cfg_pkg::IDX_OUT_FORMAT][cfg_pkg::TWO_LANE_BIT];
  assign msb_first_en = reg_q[cfg_pkg::IDX_OUT_FORMAT][cfg_pkg::MSB_FIRST_BIT];
  assign twos_comp_en = reg_q[cfg_pkg::IDX_OUT_FORMAT][cfg_pkg::TWOS_COMP_BIT];
  assign pd_pin_partial = reg_q[cfg_pkg::IDX_POWER_DOWN][cfg_pkg::PD_PIN_CFG_BIT];
  assign sync_enable = reg_q[cfg_pkg::IDX_SYNC][cfg_pkg::SYNC_EN_BIT];

  // Checks
  sequence write_sync_s;
    clk_en && fr.word_valid && !soft_rst_reg && word_addr == 8'h02;
  endsequence

  sequence rb_addr_s;
    clk_en && readback_on && !soft_rst_reg && fr.addr_valid;
  endsequence

  write_commit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (write_sync_s and !readback_on) |=> reg_q[1] == ($past(fr.word[15:0]) & 16'h2000))
    else $error("write not committed");

  write_block_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (write_sync_s and readback_on) |=> $stable(reg_q[1]))
    else $error("write accepted in readback mode");

  soft_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && soft_rst_reg |=> reg_q[0] == 16'h0000 && reg_q[12] == 16'h0000 && !soft_rst_reg)
    else $error("soft reset did not clear");

  float_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && !readback_on |=> readback_output_oe_n)
    else $error("readback output driven outside readback");

  no_read_01_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rb_addr_s and fr.addr == 8'h01) |=> !readback_output && rb_shift_reg == 16'h0000)
    else $error("register 01h read back");

  msb_first_out_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rb_addr_s and fr.addr == 8'h0F) |=> readback_output == $past(reg_q[3][15])
      && rb_cnt_reg == 5'h0F)
    else $error("readback did not start with MSB");

  ref_mode_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && ext_mode && ref_src == 2'h0 |=> ref_amp_powerdown && !vcm_ref_input)
    else $error("pin reference mode not decoded");

  internal_ref_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_en && !ext_mode |=> !ref_amp_powerdown && !vcm_ref_input)
    else $error("internal reference not kept");
endmodule

//--- tb/ctrl_model.sv
// External controller model driving the serial configuration pins
`timescale 1ns/1ps
module ctrl_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic select_n,
  output logic serial_clock,
  output logic serial_input,
  input wire logic rb_pin
);
  logic active;
  logic [15:0] rb_word;
  event rb_done;
  // Pins idle with select high and the serial clock parked low
  initial
  begin
    select_n = 1'b1;
    serial_clock = 1'b0;
    serial_input = 1'b0;
    active = 1'b0;
    rb_word = 16'h0000;
  end
  // Idle data line keeps changing so a stale level never looks valid
  always @(posedge core_clk)
    if (!active)
      serial_input <= ~serial_input;
  // Open a select period
  task automatic sel_on();
    active = 1'b1;
    @(posedge core_clk);
    select_n <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // Close it once the last commit has landed
  task automatic sel_off();
    repeat (4) @(posedge core_clk);
    select_n <= 1'b1;
    @(posedge core_clk);
    active = 1'b0;
  endtask
  // Shift n bits, address MSB first; data is set while the clock is low
  task automatic send_bits(input logic [23:0] w, input int n, input int half);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      serial_input <= w[23-i];
      repeat (half) @(posedge core_clk);
      serial_clock <= 1'b1;
      if (i >= 8)
        rb_word[23-i] <= rb_pin;
      repeat (half) @(posedge core_clk);
      serial_clock <= 1'b0;
    end
  endtask
  // One readback frame: address, then 16 clocks of returned data
  task automatic rd(input logic [7:0] a, input int half);
    sel_on();
    send_bits({a, 16'h0001}, 24, half);
    sel_off();
    ->rb_done;
  endtask
endmodule

//--- tb/adc_serial_config_port_tb.sv
// Self-checking bench of the serial configuration port
`timescale 1ns/1ps
module adc_serial_config_port_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  wire select_n, serial_clock, serial_input;
  logic readback_output, readback_output_oe_n;
  logic [cfg_pkg::NREG*16-1:0] reg_flat;
  logic ref_amp_powerdown, vcm_ref_input, two_lane_en, msb_first_en, twos_comp_en;
  logic pd_pin_partial, sync_enable;
  logic [15:0] shadow [cfg_pkg::NREG];
  logic [15:0] exp_q [$];
  logic [15:0] d;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 2669;
  int half;
  int base;
  // Readback pin level as the controller sees it
  wire rb_pin = readback_output_oe_n ? 1'bz : readback_output;

  adc_serial_config_port adc_serial_config_port_i (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .select_n(select_n), .serial_clock(serial_clock), .serial_input(serial_input),
    .readback_output(readback_output), .readback_output_oe_n(readback_output_oe_n),
    .reg_flat(reg_flat), .ref_amp_powerdown(ref_amp_powerdown),
    .vcm_ref_input(vcm_ref_input), .two_lane_en(two_lane_en),
    .msb_first_en(msb_first_en), .twos_comp_en(twos_comp_en),
    .pd_pin_partial(pd_pin_partial), .sync_enable(sync_enable)
  );
  ctrl_model ctrl_i (
    .core_clk(core_clk), .select_n(select_n), .serial_clock(serial_clock),
    .serial_input(serial_input), .rb_pin(rb_pin)
  );

  always #10 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // Hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // Each finished readback frame is compared with the oldest note
  always @(ctrl_i.rb_done)
    check(ctrl_i.rb_word, exp_q.pop_front());

  function automatic int idx_of(input logic [7:0] a);
    idx_of = -1;
    for (int i = 0; i < cfg_pkg::NREG; i++)
      if (cfg_pkg::REG_ADDR[i] == a)
        idx_of = i;
  endfunction

  // Reference model of one committed word
  task automatic commit(input logic [7:0] a, input logic [15:0] v);
    int k;
    k = idx_of(a);
    if (shadow[0][0] && a != 8'h01)
      return;
    if (a == 8'h00 && v[0])
      foreach (shadow[j]) shadow[j] = 16'h0000;
    else if (k >= 0)
      shadow[k] = v & cfg_pkg::REG_MASK[k];
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    half = base + ($random(seed) & 3);
    ctrl_i.sel_on();
    ctrl_i.send_bits({a, v}, 24, half);
    ctrl_i.sel_off();
    commit(a, v);
    repeat (4) @(posedge core_clk);
  endtask

  // 01h and unmapped places return zero
  task automatic rd(input logic [7:0] a);
    int k;
    k = idx_of(a);
    exp_q.push_back((k > 0) ? shadow[k] : 16'h0000);
    half = base + ($random(seed) & 3);
    ctrl_i.rd(a, half);
    commit(a, 16'h0001);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic check_all();
    for (int i = 0; i < cfg_pkg::NREG; i++)
      check(reg_flat[i*16 +: 16], shadow[i]);
  endtask

  initial
  begin
    foreach (shadow[j]) shadow[j] = 16'h0000;
    base = 2;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Defaults after reset
    check(readback_output_oe_n, 1'b1);
    check(two_lane_en, 1'b0);
    check({msb_first_en, twos_comp_en}, 2'h0);
    check(pd_pin_partial, 1'b0);
    check(ref_amp_powerdown, 1'b0);
    // Every register back to back in one select, then a stray tail
    ctrl_i.sel_on();
    for (int i = 0; i < cfg_pkg::NREG; i++)
    begin
      d = 16'($random(seed));
      if (i == 0)
        d[0] = 1'b0;
      half = 2 + ($random(seed) & 3);
      ctrl_i.send_bits({cfg_pkg::REG_ADDR[i], d}, 24, half);
      commit(cfg_pkg::REG_ADDR[i], d);
    end
    ctrl_i.send_bits({8'h0A, 16'h1234}, 23, 2);
    ctrl_i.sel_off();
    repeat (4) @(posedge core_clk);
    check_all();
    check({two_lane_en, twos_comp_en, msb_first_en},
          {shadow[11][0], shadow[11][2], shadow[11][3]});
    check({pd_pin_partial, sync_enable}, {shadow[3][10], shadow[1][13]});
    // Clock enable low freezes the port, so a whole word goes unseen
    clk_en <= 1'b0;
    ctrl_i.sel_on();
    ctrl_i.send_bits({8'h0A, 16'h5A5A}, 24, 2);
    ctrl_i.sel_off();
    clk_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    check_all();
    // Word cut short by select going high, then two clean words, the second at a slow serial clock
    ctrl_i.sel_on();
    ctrl_i.send_bits({8'h23, 16'hA5A5}, 12, 2);
    ctrl_i.sel_off();
    wr(8'h14, 16'hFFFF);
    base = 40;
    wr(8'h0A, 16'hBEEF);
    base = 2;
    check_all();
    // Reference mode decode over all enables and source codes, mixed codes too
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h01, {11'h000, k[2], 4'h0});
      wr(8'hF0, {k[1], 15'h0000});
      wr(8'h42, {k[0], 11'h000, k[0] ^ k[3], 3'h0});
      repeat (2) @(posedge core_clk);
      check(ref_amp_powerdown, k[2] & k[1] & ~k[0] & ~k[3]);
      check(vcm_ref_input, k[2] & k[1] & k[0] & ~k[3]);
    end
    // Readback mode: writes blocked, soft reset blocked too
    wr(8'h01, 16'h0001);
    check(readback_output_oe_n, 1'b0);
    wr(8'h0A, 16'h0F0F);
    rd(8'h00);
    for (int i = 0; i < cfg_pkg::NREG; i++)
      rd(cfg_pkg::REG_ADDR[i]);
    rd(8'h55);
    // Reset pin pulse of one clock while in readback
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    foreach (shadow[j]) shadow[j] = 16'h0000;
    repeat (2) @(posedge core_clk);
    check(readback_output_oe_n, 1'b1);
    check_all();
    // Leave readback and write again
    wr(8'h01, 16'h0001);
    wr(8'h01, 16'h0000);
    check(readback_output_oe_n, 1'b1);
    wr(8'h0A, 16'hC3C3);
    check_all();
    // Soft reset clears everything
    wr(8'h00, 16'h0001);
    check_all();
    check(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule
